// file: logic/force_disarm_pkg.sv
/*
  Shared constants and types for the relay output force/disarm block.
  Assumes one 250 MHz clock and a synchronous active-high reset.
*/
package force_disarm_pkg;

  localparam int NUM_GROUPS = 2;
  localparam int OUTS_PER_GROUP = 4;
  localparam int NUM_OUTS = NUM_GROUPS * OUTS_PER_GROUP;
  localparam int TIME_W = 16;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FORCE_VAL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GRP_VAL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FORCE_CMD = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_DISARM_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FORCE_TIME = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DISARM_TIME = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1c;

  // field positions
  localparam int CTRL_DIS_EN_BIT = 0;
  localparam int FCMD_GRP_LSB = 8;
  localparam int FCMD_PERM_BIT = 12;
  localparam int FCMD_REL_BIT = 13;
  localparam int DCMD_PERM_BIT = 4;
  localparam int DCMD_REL_BIT = 5;
  localparam int STAT_DIS_LSB = 8;
  localparam int STAT_FRC_LSB = 16;
  localparam int STAT_GRP_LSB = 24;
  localparam int STAT_ZONE_BIT = 28;
  localparam int STAT_SUPV_BIT = 29;

  // reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [NUM_OUTS-1:0] FORCE_VAL_RST = 8'h00;
  localparam logic [NUM_GROUPS-1:0] GRP_VAL_RST = 2'h0;
  localparam logic [TIME_W-1:0] TIME_RST = 16'h0001;

  // time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_TIMED = 2'b01,
    T_PERM = 2'b10
  } timer_state_t;

  typedef struct packed {
    logic [NUM_OUTS-1:0] cmd;
    logic [NUM_OUTS-1:0] latched;
    logic [NUM_OUTS-1:0] hold_run;
    logic zone_cmd;
    logic supv_cmd;
  } contact_in_t;

  typedef struct packed {
    logic [NUM_OUTS-1:0] relay;
    logic zone;
    logic supv;
  } contact_out_t;

endpackage

// file: logic/hold_timer.sv
/*
  Timed or permanent hold state, counted in time-base ticks.
  Assumes load and clear are one-cycle pulses; clear wins over load.
*/
`timescale 1ns/10ps
module hold_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic perm,
  input wire logic clear,
  input wire logic [force_disarm_pkg::TIME_W-1:0] len,
  output logic active
);

  force_disarm_pkg::timer_state_t state;
  force_disarm_pkg::timer_state_t next_state;
  logic [force_disarm_pkg::TIME_W-1:0] cnt;
  logic [force_disarm_pkg::TIME_W-1:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (clear) begin
      next_state = force_disarm_pkg::T_IDLE;
      next_cnt = '0;
    end else if (load && (state != force_disarm_pkg::T_PERM)) begin
      // permanent hold ends only on release; zero length is a no-op
      if (perm) begin
        next_state = force_disarm_pkg::T_PERM;
      end else if (len != '0) begin
        next_state = force_disarm_pkg::T_TIMED;
        next_cnt = len;
      end
    end else begin
      unique case (state)
        force_disarm_pkg::T_IDLE: begin
        end
        force_disarm_pkg::T_TIMED: begin
          if (tick) begin
            if (cnt == 16'h0001) begin
              next_state = force_disarm_pkg::T_IDLE;
              next_cnt = '0;
            end else begin
              next_cnt = cnt - 16'h0001;
            end
          end
        end
        force_disarm_pkg::T_PERM: begin
        end
        default: begin
          next_state = force_disarm_pkg::T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= force_disarm_pkg::T_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign active = (state != force_disarm_pkg::T_IDLE);

  property p_expire;
    @(posedge clk) disable iff (rst)
    (state == force_disarm_pkg::T_TIMED && tick && cnt == 16'h0001 && !load && !clear)
      |=> !active;
  endproperty
  a_expire: assert property (p_expire) else $error("timed hold did not expire");

  property p_perm_hold;
    @(posedge clk) disable iff (rst)
    (state == force_disarm_pkg::T_PERM && !clear) |=> (state == force_disarm_pkg::T_PERM);
  endproperty
  a_perm_hold: assert property (p_perm_hold) else $error("permanent hold dropped");

  property p_release;
    @(posedge clk) disable iff (rst)
    clear |=> !active;
  endproperty
  a_release: assert property (p_release) else $error("release did not clear hold");

endmodule

// file: logic/output_force_disarm_control.sv
/*
  Test-mode force and disarm override between protection relay commands
  and the relay contact drivers, with a plain register port.
  Assumes contact inputs are synchronous to clk; read data one cycle late.
*/
`timescale 1ns/10ps
module output_force_disarm_control #(
  parameter int TICK_CYCLES = force_disarm_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [force_disarm_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire force_disarm_pkg::contact_in_t contact_in,
  output force_disarm_pkg::contact_out_t contact_out
);

  localparam int NO = force_disarm_pkg::NUM_OUTS;
  localparam int NG = force_disarm_pkg::NUM_GROUPS;
  localparam int OPG = force_disarm_pkg::OUTS_PER_GROUP;
  localparam int TW = force_disarm_pkg::TIME_W;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

  // settings
  logic disarm_en;
  logic next_disarm_en;
  logic [NO-1:0] force_val;
  logic [NO-1:0] next_force_val;
  logic [NG-1:0] grp_val;
  logic [NG-1:0] next_grp_val;
  logic [TW-1:0] force_time;
  logic [TW-1:0] next_force_time;
  logic [TW-1:0] disarm_time;
  logic [TW-1:0] next_disarm_time;

  // time base
  logic [CW-1:0] tick_cnt;
  logic [CW-1:0] next_tick_cnt;
  logic tick;

  // command decode
  logic force_wr;
  logic dis_wr;
  logic f_perm;
  logic f_rel;
  logic d_perm;
  logic d_rel;
  logic [NO-1:0] single_sel;
  logic [NG-1:0] grp_sel;
  logic [NG-1:0] dis_sel;
  logic [NO-1:0] single_load;
  logic [NO-1:0] single_clear;
  logic [NG-1:0] grp_load;
  logic [NG-1:0] grp_clear;
  logic [NG-1:0] dis_load;
  logic [NG-1:0] dis_clear;

  // hold states
  logic [NO-1:0] single_on;
  logic [NG-1:0] grp_on;
  logic [NG-1:0] dis_on;
  logic [NO-1:0] grp_vec;
  logic [NO-1:0] dis_vec;
  logic [NO-1:0] fval;
  logic [NO-1:0] blocked;
  logic [NO-1:0] eff_force;

  // contact state
  logic [NO-1:0] disarmed;
  logic [NO-1:0] next_disarmed;
  logic [NO-1:0] relay;
  logic [NO-1:0] next_relay;
  logic zone;
  logic next_zone;
  logic supv;
  logic next_supv;

  logic [31:0] next_rdata;

  // settings registers
  always_comb begin
    next_disarm_en = disarm_en;
    next_force_val = force_val;
    next_grp_val = grp_val;
    next_force_time = force_time;
    next_disarm_time = disarm_time;
    if (wr) begin
      unique case (addr)
        force_disarm_pkg::REG_CTRL: begin
          next_disarm_en = wdata[force_disarm_pkg::CTRL_DIS_EN_BIT];
        end
        force_disarm_pkg::REG_FORCE_VAL: begin
          next_force_val = wdata[NO-1:0];
        end
        force_disarm_pkg::REG_GRP_VAL: begin
          next_grp_val = wdata[NG-1:0];
        end
        force_disarm_pkg::REG_FORCE_TIME: begin
          next_force_time = wdata[TW-1:0];
        end
        force_disarm_pkg::REG_DISARM_TIME: begin
          next_disarm_time = wdata[TW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      disarm_en <= force_disarm_pkg::CTRL_RST;
      force_val <= force_disarm_pkg::FORCE_VAL_RST;
      grp_val <= force_disarm_pkg::GRP_VAL_RST;
      force_time <= force_disarm_pkg::TIME_RST;
      disarm_time <= force_disarm_pkg::TIME_RST;
    end else begin
      disarm_en <= next_disarm_en;
      force_val <= next_force_val;
      grp_val <= next_grp_val;
      force_time <= next_force_time;
      disarm_time <= next_disarm_time;
    end
  end

  always_comb begin
    tick = (tick_cnt == TICK_LAST);
    next_tick_cnt = tick ? '0 : tick_cnt + CW'(1);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // command strobes; a write with the release bit clears the selection
  always_comb begin
    force_wr = wr && (addr == force_disarm_pkg::REG_FORCE_CMD);
    dis_wr = wr && (addr == force_disarm_pkg::REG_DISARM_CMD);
    f_perm = wdata[force_disarm_pkg::FCMD_PERM_BIT];
    f_rel = wdata[force_disarm_pkg::FCMD_REL_BIT];
    d_perm = wdata[force_disarm_pkg::DCMD_PERM_BIT];
    d_rel = wdata[force_disarm_pkg::DCMD_REL_BIT];
    single_sel = force_wr ? wdata[NO-1:0] : '0;
    grp_sel = force_wr ? wdata[force_disarm_pkg::FCMD_GRP_LSB +: NG] : '0;
    dis_sel = dis_wr ? wdata[NG-1:0] : '0;
    // single force taken only when not disarmed; group force load is not gated
    single_load = single_sel & ~disarmed & {NO{~f_rel}};
    single_clear = single_sel & {NO{f_rel}};
    grp_load = grp_sel & {NG{~f_rel}};
    grp_clear = grp_sel & {NG{f_rel}};
    // disarm needs enable and a command
    dis_load = dis_sel & {NG{~d_rel & disarm_en}};
    dis_clear = (dis_sel & {NG{d_rel}}) | {NG{~disarm_en}};
  end

  genvar i;
  genvar g;

  generate
    for (i = 0; i < NO; i++) begin : g_single
      hold_timer u_single (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(single_load[i]),
        .perm(f_perm),
        .clear(single_clear[i]),
        .len(force_time),
        .active(single_on[i])
      );
    end
  endgenerate

  // group force and group disarm holds
  generate
    for (g = 0; g < NG; g++) begin : g_group
      hold_timer u_grp_force (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(grp_load[g]),
        .perm(f_perm),
        .clear(grp_clear[g]),
        .len(force_time),
        .active(grp_on[g])
      );
      hold_timer u_grp_disarm (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .load(dis_load[g]),
        .perm(d_perm),
        .clear(dis_clear[g]),
        .len(disarm_time),
        .active(dis_on[g])
      );
    end
  endgenerate

  // group force value overrides single value
  generate
    for (i = 0; i < NO; i++) begin : g_map
      assign grp_vec[i] = grp_on[i / OPG];
      assign dis_vec[i] = dis_on[i / OPG];
      assign fval[i] = grp_on[i / OPG] ? grp_val[i / OPG] : force_val[i];
    end
  endgenerate

  always_comb begin
    blocked = contact_in.latched | contact_in.hold_run;
    // disarm waits for latch and hold timer
    next_disarmed = dis_vec & {NO{disarm_en}} & (disarmed | ~blocked);
    // force applies only to armed outputs
    eff_force = (grp_vec | single_on) & ~disarmed;
    next_relay = (relay & disarmed)
               | (fval & eff_force)
               | (contact_in.cmd & ~disarmed & ~eff_force);
    next_zone = contact_in.zone_cmd;
    next_supv = contact_in.supv_cmd;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      disarmed <= '0;
      relay <= '0;
      zone <= 1'b0;
      supv <= 1'b0;
    end else begin
      disarmed <= next_disarmed;
      relay <= next_relay;
      zone <= next_zone;
      supv <= next_supv;
    end
  end

  assign contact_out.relay = relay;
  assign contact_out.zone = zone;
  assign contact_out.supv = supv;

  // command registers read as zero; unmapped addresses too
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      unique case (addr)
        force_disarm_pkg::REG_CTRL: begin
          next_rdata[force_disarm_pkg::CTRL_DIS_EN_BIT] = disarm_en;
        end
        force_disarm_pkg::REG_FORCE_VAL: begin
          next_rdata[NO-1:0] = force_val;
        end
        force_disarm_pkg::REG_GRP_VAL: begin
          next_rdata[NG-1:0] = grp_val;
        end
        force_disarm_pkg::REG_FORCE_TIME: begin
          next_rdata[TW-1:0] = force_time;
        end
        force_disarm_pkg::REG_DISARM_TIME: begin
          next_rdata[TW-1:0] = disarm_time;
        end
        force_disarm_pkg::REG_STATUS: begin
          next_rdata[NO-1:0] = relay;
          next_rdata[force_disarm_pkg::STAT_DIS_LSB +: NO] = disarmed;
          next_rdata[force_disarm_pkg::STAT_FRC_LSB +: NO] = eff_force;
          next_rdata[force_disarm_pkg::STAT_GRP_LSB +: NG] = dis_on;
          next_rdata[force_disarm_pkg::STAT_ZONE_BIT] = zone;
          next_rdata[force_disarm_pkg::STAT_SUPV_BIT] = supv;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  property p_grp_prio;
    @(posedge clk) disable iff (rst)
    ((grp_vec & ~disarmed) != '0)
      |=> (((relay ^ $past(grp_val[0] ? 8'h0f : 8'h00) ^ $past(grp_val[1] ? 8'hf0 : 8'h00))
            & $past(grp_vec & ~disarmed)) == '0);
  endproperty
  a_grp_prio: assert property (p_grp_prio) else $error("group force value not applied");

  property p_ignore_force;
    @(posedge clk) disable iff (rst)
    ((single_sel & disarmed & ~single_on) != '0)
      |=> ((single_on & $past(single_sel & disarmed & ~single_on)) == '0);
  endproperty
  a_ignore_force: assert property (p_ignore_force) else $error("disarmed output took force");

  property p_single_force;
    @(posedge clk) disable iff (rst)
    ((single_on & ~grp_vec & ~disarmed) != '0)
      |=> (((relay ^ $past(force_val)) & $past(single_on & ~grp_vec & ~disarmed)) == '0);
  endproperty
  a_single_force: assert property (p_single_force) else $error("single force not applied");

  property p_no_switch;
    @(posedge clk) disable iff (rst)
    (disarmed != '0) |=> ((relay & $past(disarmed)) == $past(relay & disarmed));
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("disarmed contact switched");

  property p_zone_free;
    @(posedge clk) disable iff (rst)
    (dis_on != '0) ##1 1'b1 |-> (zone == $past(contact_in.zone_cmd))
      && (supv == $past(contact_in.supv_cmd));
  endproperty
  a_zone_free: assert property (p_zone_free) else $error("zone or supervision blocked");

  property p_latch_wait;
    @(posedge clk) disable iff (rst)
    ((blocked & ~disarmed) != '0) |=> ((disarmed & $past(blocked & ~disarmed)) == '0);
  endproperty
  a_latch_wait: assert property (p_latch_wait) else $error("blocked output disarmed");

  property p_enable_off;
    @(posedge clk) disable iff (rst)
    !disarm_en |=> (disarmed == '0) && (dis_on == '0);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("disarm while enable off");

  property p_need_cmd;
    @(posedge clk) disable iff (rst)
    (dis_on == '0 && dis_load == '0) |=> (dis_on == '0) ##1 (disarmed == '0);
  endproperty
  a_need_cmd: assert property (p_need_cmd) else $error("disarm without command");

endmodule

// file: sim/relay_side_model.sv
/*
  Far-side model: protection trip logic feeding commands and contact
  flags into the block, and relay drivers counting contact changes.
  Assumes the bench sets the request inputs just after a rising edge.
*/
`timescale 1ns/10ps
module relay_side_model (
  input wire logic clk,
  input wire logic [7:0] cmd,
  input wire logic [7:0] latched,
  input wire logic [7:0] hold_run,
  input wire logic zone_cmd,
  input wire logic supv_cmd,
  input wire force_disarm_pkg::contact_out_t contact_out,
  output force_disarm_pkg::contact_in_t contact_in,
  output int switch_count
);
  logic [7:0] last_relay;
  initial begin
    contact_in = '0;
    switch_count = 0;
    last_relay = 8'h00;
  end
  // trip logic is registered: lines move one edge after the request
  always @(posedge clk) begin
    contact_in <= {cmd, latched, hold_run, zone_cmd, supv_cmd};
    if (contact_out.relay !== last_relay) switch_count <= switch_count + 1;
    last_relay <= contact_out.relay;
  end
endmodule

// file: sim/test_output_force_disarm_control.sv
/*
  Self-checking bench for the force/disarm block against a small model.
  Assumes a 4-cycle time-base tick so that timeouts stay short.
*/
`timescale 1ns/10ps
module test_output_force_disarm_control;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  force_disarm_pkg::contact_in_t contact_in;
  force_disarm_pkg::contact_out_t contact_out;
  logic [7:0] cmd_v = 8'h00;
  logic [7:0] latched_v = 8'h00;
  logic [7:0] hold_v = 8'h00;
  logic zone_v = 1'b0;
  logic supv_v = 1'b0;
  logic [7:0] fval, smask, dmask, frz;
  logic [1:0] gval, gmask;
  logic [31:0] r;
  int switch_count, n, sc;
  int bad_count = 0;
  int comparisons = 0;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};

  always #2 clk = ~clk;

  output_force_disarm_control #(.TICK_CYCLES(TK)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .contact_in(contact_in), .contact_out(contact_out)
  );

  relay_side_model u_side (
    .clk(clk), .cmd(cmd_v), .latched(latched_v), .hold_run(hold_v),
    .zone_cmd(zone_v), .supv_cmd(supv_v), .contact_out(contact_out),
    .contact_in(contact_in), .switch_count(switch_count)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic drive(input logic [7:0] c, input logic [7:0] l, input logic [7:0] h);
    @(posedge clk);
    cmd_v <= c;
    latched_v <= l;
    hold_v <= h;
    zone_v <= 1'($urandom);
    supv_v <= 1'($urandom);
  endtask

  // disarm freezes, group force beats single force
  function automatic logic [7:0] exp_relay();
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      if (dmask[i]) e[i] = frz[i];
      else if (gmask[i/4]) e[i] = gval[i/4];
      else if (smask[i]) e[i] = fval[i];
      else e[i] = cmd_v[i];
    end
    return e;
  endfunction

  task automatic cmp_all();
    settle(4);
    check("relay", 32'(contact_out.relay), 32'(exp_relay())); // priority
    check("zone", 32'(contact_out.zone), 32'(zone_v)); // never disarmed
    check("supv", 32'(contact_out.supv), 32'(supv_v)); // never disarmed
    rd_reg(force_disarm_pkg::REG_STATUS, r);
    check("disarmed", 32'(r[15:8]), 32'(dmask)); // per output
    check("forced", 32'(r[23:16]),
          32'((smask | {{4{gmask[1]}}, {4{gmask[0]}}}) & ~dmask)); // force ignored
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    r = $urandom(32'h8bd1f79a);
    {fval, smask, dmask, frz, gval, gmask} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      rd_reg(ra[k], r);
      check("reset value", r, rv[k]); // cleared state; both times reset to 1
    end
    for (int k = 0; k < 3; k++) begin
      drive(8'($urandom), 8'h00, 8'h00);
      cmp_all(); // normal path
    end
    fval = 8'($urandom);
    wr_reg(force_disarm_pkg::REG_FORCE_VAL, 32'(fval));
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h000010ff);
    smask = 8'hff;
    drive(~fval, 8'h00, 8'h00);
    settle(40);
    cmp_all(); // no expiry
    gval = 2'b01;
    wr_reg(force_disarm_pkg::REG_GRP_VAL, 32'h00000001);
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h00001100);
    gmask = 2'b01;
    cmp_all(); // group wins
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h000023ff);
    smask = 8'h00;
    gmask = 2'b00;
    cmp_all(); // release
    fval = ~cmd_v;
    wr_reg(force_disarm_pkg::REG_FORCE_TIME, 32'h00000003);
    wr_reg(force_disarm_pkg::REG_FORCE_VAL, 32'(fval));
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h000000ff);
    settle(3);
    check("timed force", 32'(contact_out.relay), 32'(fval)); // forced
    n = 0;
    while (contact_out.relay !== cmd_v && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    // first tick lands anywhere in one tick period, so allow that jitter
    check("timed length", 32'(n >= 2 * TK - 1 && n <= 3 * TK - 2), 32'h1); // expiry
    // disarm gated by enable and command
    wr_reg(force_disarm_pkg::REG_DISARM_CMD, 32'h00000012);
    drive(8'($urandom), 8'h00, 8'h00);
    cmp_all(); // enable off
    wr_reg(force_disarm_pkg::REG_CTRL, 32'h00000001);
    cmp_all(); // no command yet
    // latched and hold timer delay disarm
    drive(cmd_v, 8'h20, 8'h40);
    settle(3);
    frz = exp_relay();
    wr_reg(force_disarm_pkg::REG_DISARM_CMD, 32'h00000012);
    dmask = 8'h90;
    drive(~cmd_v, 8'h20, 8'h40);
    cmp_all(); // frozen
    drive(cmd_v, 8'h00, 8'h00);
    frz = exp_relay();
    dmask = 8'hf0;
    cmp_all(); // released
    wr_reg(force_disarm_pkg::REG_FORCE_VAL, 32'(~frz));
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h00001010);
    drive(8'($urandom), 8'h00, 8'h00);
    cmp_all();
    // no switching while both groups disarmed
    wr_reg(force_disarm_pkg::REG_DISARM_CMD, 32'h00000013);
    settle(3);
    frz = exp_relay();
    dmask = 8'hff;
    sc = switch_count;
    drive(~cmd_v, 8'h00, 8'h00);
    settle(40);
    check("switching", switch_count, sc); // no switching
    cmp_all(); // held
    wr_reg(force_disarm_pkg::REG_DISARM_CMD, 32'h00000023);
    dmask = 8'h00;
    cmp_all(); // withdrawn
    wr_reg(force_disarm_pkg::REG_DISARM_TIME, 32'h00000002);
    wr_reg(force_disarm_pkg::REG_DISARM_CMD, 32'h00000001);
    settle(1);
    rd_reg(force_disarm_pkg::REG_STATUS, r);
    check("timed disarm", 32'(r[15:8]), 32'h0000000f); // running
    n = 0;
    while (r[15:8] !== 8'h00 && n < 12) begin
      rd_reg(force_disarm_pkg::REG_STATUS, r);
      n++;
    end
    drive(8'($urandom), 8'h00, 8'h00);
    cmp_all(); // expired
    gval = 2'b10;
    wr_reg(force_disarm_pkg::REG_GRP_VAL, 32'h00000002);
    wr_reg(force_disarm_pkg::REG_FORCE_CMD, 32'h00001200);
    gmask = 2'b10;
    cmp_all(); // group permanent
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    gmask = 2'b00;
    cmp_all(); // reset clears
    rd_reg(force_disarm_pkg::REG_CTRL, r);
    check("ctrl after reset", r, 32'h00000000); // enable cleared
    final_report();
  end
endmodule
